// *** verilog/tpc_pkg.sv ***
// Package of constants and carriers for the timer and prescaler control block.
`default_nettype none
package tpc_pkg;
  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_TIMER_HIGH = 8'h19;
  localparam logic [7:0] ADDR_TIMER3_HIGH = 8'h1C;
  localparam logic [7:0] ADDR_SECOND_INT = 8'h1F;
  localparam logic [7:0] ADDR_TIMER1_COUNT = 8'h00;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_TIMER0_MODE = 8'h3F;
  localparam logic [7:0] RST_SECOND_INT = 8'h00;
  localparam logic [7:0] RST_PRESCALE = 8'hFF;
  localparam logic [7:0] RST_HIGH_BITS = 8'h00;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int MODE_OWNER_BIT = 3;
  localparam int MODE_EDGE_BIT = 4;
  localparam int MODE_SOURCE_BIT = 5;
  localparam int MODE_SLOW_BIT = 7;
  localparam int T3_ENABLE_BIT = 0;
  localparam int T3_FLAG_BIT = 4;
  localparam int PWM_LO_LSB = 0;
  localparam int PWM_HI_LSB = 2;
  localparam int TA_LSB = 4;
  localparam int TB_LSB = 6;
  localparam logic [2:0] RATE_MAX = 3'h7;
  localparam logic [9:0] COUNT_ALL_ONES = 10'h3FF;
  // Register file read and write strobe carrier.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } tpc_access_s;
  // Timer0 mode register layout.
  typedef struct packed {
    logic slow_osc_source_select;
    logic spare_mode_bit;
    logic tick_source_select;
    logic tick_edge_select;
    logic prescale_owner_select;
    logic [2:0] prescale_rate_select;
  } tpc_mode_s;
endpackage
`default_nettype wire

// *** verilog/tpc_timer_prescaler_control.sv ***
// Timer0 clock selection, shared prescaler and timer high-byte registers.
`default_nettype none
// Summary of operation
// - Timer0 owner divides by two to the power rate plus one, 1:2 to 1:256.
// - Watchdog reset mode divides one step lower, 1:1 to 1:128.
// - Watchdog interrupt mode uses the Timer0 rates, 1:2 to 1:256.
// - Mode bit 3 set routes the prescaler to watchdog, clear to Timer0.
// - Mode bit 4 set counts falling edges of the count pin, else rising.
// - The same edge choice applies to the slow oscillator source.
// - Bit 5 clear picks instruction clock; set picks pin or slow oscillator by bit 7.
// - Mode register has no address; two dedicated instructions access it.
// - High-byte bits 5:4 write Timer1 load bits 9:8, read live count bits.
// - High-byte bits 7:6 write Timer2 load bits 9:8, read live count bits.
// - Timer3 high-byte bits 5:4 write load bits 9:8, read live count bits.
// - Shared high byte holds PWM1 upper duty in 1:0, PWM2 in 3:2.
// - Timer3 high byte holds PWM3 upper duty in 1:0, PWM4 in 3:2.
// - Timer3 underflow interrupt is allowed only while enable bit 0 is one.
// - Timer3 underflow sets flag bit 4; firmware clears it by writing zero.
// - A Timer1 count write loads the full 10-bit value from load bits.
// - Timer0 counts only while its run bit is one.
// - Overflow sets the Timer0 flag; firmware clears; disabled flag reads zero.
module tpc_timer_prescaler_control
  import tpc_pkg::*;
(
  input wire logic mclk, // Instruction clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic sfr_wr, // Register write strobe.
  input wire logic sfr_rd, // Register read strobe.
  input wire logic [7:0] sfr_addr, // Register address.
  input wire logic [7:0] sfr_wdata, // Register write data.
  output logic [7:0] sfr_rdata, // Registered read data.
  input wire logic mode_write_instr, // Dedicated mode write instruction.
  input wire logic mode_readback_instr, // Dedicated mode read instruction.
  output logic [7:0] mode_rdata, // Registered mode read data.
  input wire logic ext_count_pin, // External count pin, asynchronous.
  input wire logic slow_osc_clk, // Slow oscillator output, asynchronous.
  input wire logic timer0_run, // Timer0 run bit.
  input wire logic timer0_int_enable, // Timer0 overflow enable bit.
  input wire logic timer0_flag_clear, // Firmware clears the overflow flag.
  input wire logic wdt_int_mode, // Watchdog uses interrupt mechanism.
  input wire logic wdt_tick, // Watchdog base tick pulse.
  output logic wdt_timeout, // Watchdog timeout pulse.
  input wire logic [9:0] timer1_live, // Timer1 live count.
  input wire logic [9:0] timer2_live, // Timer2 live count.
  input wire logic [9:0] timer3_live, // Timer3 live count.
  input wire logic timer3_underflow, // Timer3 underflow pulse.
  output logic [1:0] timer1_upper_bits, // Timer1 load bits 9:8.
  output logic [1:0] timer2_upper_bits, // Timer2 load bits 9:8.
  output logic [1:0] timer3_upper_bits, // Timer3 load bits 9:8.
  output logic timer1_count_load, // Pulse: load full Timer1 count.
  output logic [1:0] pwm1_duty_upper, // PWM1 duty bits 9:8.
  output logic [1:0] pwm2_duty_upper, // PWM2 duty bits 9:8.
  output logic [1:0] pwm3_duty_upper, // PWM3 duty bits 9:8.
  output logic [1:0] pwm4_duty_upper, // PWM4 duty bits 9:8.
  output logic [7:0] timer0_count, // Timer0 count.
  output logic [7:0] prescale_count, // Prescaler counter value.
  output logic timer0_overflow_flag, // Timer0 flag as read.
  output logic timer3_underflow_flag, // Timer3 flag as read.
  output logic timer3_irq // Timer3 interrupt request.
);
  tpc_mode_s mode;
  tpc_access_s acc;
  logic t3_enable;
  logic t3_flag;
  logic t0_flag;
  logic pin_s1, pin_s2, pin_s3;
  logic osc_s1, osc_s2, osc_s3;
  logic src_now, src_last, ext_edge, tick;
  logic [7:0] next_prescale;
  logic div_done;
  logic t0_step;
  logic wr_t3flag_zero;

  assign acc = '{wr: sfr_wr, rd: sfr_rd, addr: sfr_addr, data: sfr_wdata};

  // Division mask: ones over the low bits, whose terminal count is all zeros.
  function automatic logic [7:0] rate_mask(input logic [2:0] rate, input logic lower);
    logic [8:0] m;
    m = 9'h000;
    m = (9'h002 << rate) - 9'h001;
    if (lower) begin
      m = m >> 1;
    end
    return m[7:0];
  endfunction

  // ----------------------------------------
  // Mode register
  // ----------------------------------------
  // Reachable only by the dedicated instructions, never by address.
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode <= RST_TIMER0_MODE;
    end else if (mode_write_instr) begin
      mode <= sfr_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_rdata <= 8'h00;
    end else if (mode_readback_instr) begin
      mode_rdata <= mode;
    end
  end

  // ----------------------------------------
  // Clock source selection
  // ----------------------------------------
  // Both asynchronous sources pass three flops before any edge logic sees them.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
      src_last <= 1'b0;
    end else begin
      pin_s1 <= ext_count_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      osc_s1 <= slow_osc_clk;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
      src_last <= src_now;
    end
  end

  // Slow oscillator replaces the pin when bit 7 is set; edge choice is shared.
  assign src_now = mode.slow_osc_source_select ? osc_s3 : pin_s3;
  assign ext_edge = mode.tick_edge_select ? (src_last & ~src_now) : (~src_last & src_now);
  // Instruction clock gives one tick per cycle.
  assign tick = mode.tick_source_select ? ext_edge : 1'b1;

  // ----------------------------------------
  // Shared prescaler
  // ----------------------------------------
  // The rate table depends on owner and watchdog mechanism together.
  logic owner_wdt;
  logic [7:0] mask;
  logic pre_adv;
  assign owner_wdt = mode.prescale_owner_select;
  assign mask = rate_mask(mode.prescale_rate_select, owner_wdt & ~wdt_int_mode);
  assign pre_adv = owner_wdt ? wdt_tick : (tick & timer0_run);
  // A division completes on the tick that finds the masked low bits at zero.
  assign div_done = pre_adv & ((prescale_count & mask) == 8'h00);
  assign next_prescale = div_done ? RST_PRESCALE : (prescale_count - 8'h01);

  // Counter runs down from all ones so the 1:1 rate completes every tick.
  always_ff @(posedge mclk) begin
    if (rst) begin
      prescale_count <= RST_PRESCALE;
    end else if (pre_adv) begin
      prescale_count <= next_prescale;
    end
  end

  // ----------------------------------------
  // Timer0 and watchdog steps
  // ----------------------------------------
  logic last_div;
  assign last_div = div_done;
  assign t0_step = last_div & ~owner_wdt & timer0_run;

  always_ff @(posedge mclk) begin
    if (rst) begin
      timer0_count <= 8'h00;
    end else if (t0_step) begin
      timer0_count <= timer0_count + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wdt_timeout <= 1'b0;
    end else begin
      wdt_timeout <= last_div & owner_wdt;
    end
  end

  // Overflow wins over a clear arriving in the same cycle.
  always_ff @(posedge mclk) begin
    if (rst) begin
      t0_flag <= 1'b0;
    end else if (t0_step && timer0_count == 8'hFF) begin
      t0_flag <= 1'b1;
    end else if (timer0_flag_clear) begin
      t0_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      timer0_overflow_flag <= 1'b0;
    end else begin
      timer0_overflow_flag <= (t0_flag | (t0_step && timer0_count == 8'hFF)) & timer0_int_enable;
    end
  end

  // ----------------------------------------
  // High-byte registers
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      timer1_upper_bits <= RST_HIGH_BITS[1:0];
      timer2_upper_bits <= RST_HIGH_BITS[1:0];
      pwm1_duty_upper <= RST_HIGH_BITS[1:0];
      pwm2_duty_upper <= RST_HIGH_BITS[1:0];
    end else if (acc.wr && acc.addr == ADDR_TIMER_HIGH) begin
      pwm1_duty_upper <= acc.data[PWM_LO_LSB +: 2];
      pwm2_duty_upper <= acc.data[PWM_HI_LSB +: 2];
      timer1_upper_bits <= acc.data[TA_LSB +: 2];
      timer2_upper_bits <= acc.data[TB_LSB +: 2];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      timer3_upper_bits <= RST_HIGH_BITS[1:0];
      pwm3_duty_upper <= RST_HIGH_BITS[1:0];
      pwm4_duty_upper <= RST_HIGH_BITS[1:0];
    end else if (acc.wr && acc.addr == ADDR_TIMER3_HIGH) begin
      pwm3_duty_upper <= acc.data[PWM_LO_LSB +: 2];
      pwm4_duty_upper <= acc.data[PWM_HI_LSB +: 2];
      timer3_upper_bits <= acc.data[TA_LSB +: 2];
    end
  end

  // The timer core loads upper bits plus its reload byte on this pulse.
  always_ff @(posedge mclk) begin
    if (rst) begin
      timer1_count_load <= 1'b0;
    end else begin
      timer1_count_load <= acc.wr && acc.addr == ADDR_TIMER1_COUNT;
    end
  end

  // ----------------------------------------
  // Second interrupt register
  // ----------------------------------------
  assign wr_t3flag_zero = acc.wr && acc.addr == ADDR_SECOND_INT && !acc.data[T3_FLAG_BIT];

  always_ff @(posedge mclk) begin
    if (rst) begin
      t3_enable <= RST_SECOND_INT[T3_ENABLE_BIT];
    end else if (acc.wr && acc.addr == ADDR_SECOND_INT) begin
      t3_enable <= acc.data[T3_ENABLE_BIT];
    end
  end

  // Underflow wins over a clearing write in the same cycle; writing one is ignored.
  always_ff @(posedge mclk) begin
    if (rst) begin
      t3_flag <= RST_SECOND_INT[T3_FLAG_BIT];
    end else if (timer3_underflow) begin
      t3_flag <= 1'b1;
    end else if (wr_t3flag_zero) begin
      t3_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      timer3_underflow_flag <= 1'b0;
      timer3_irq <= 1'b0;
    end else begin
      timer3_underflow_flag <= (t3_flag | timer3_underflow) & t3_enable;
      timer3_irq <= (t3_flag | timer3_underflow) & t3_enable;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Timer bits return the live counts, not the written load values.
  always_ff @(posedge mclk) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (acc.rd) begin
      unique case (acc.addr)
        ADDR_TIMER_HIGH: sfr_rdata <= {timer2_live[9:8], timer1_live[9:8],
                                       pwm2_duty_upper, pwm1_duty_upper};
        ADDR_TIMER3_HIGH: sfr_rdata <= {2'b00, timer3_live[9:8], pwm4_duty_upper, pwm3_duty_upper};
        ADDR_SECOND_INT: sfr_rdata <= {3'b000, t3_flag & t3_enable, 3'b000, t3_enable};
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence t3_set_s;
    timer3_underflow && t3_enable;
  endsequence

  t3_flag_set_a: assert property (@(posedge mclk) disable iff (rst) t3_set_s |=> timer3_underflow_flag)
    else $error("timer3 flag not set after underflow");
  t3_enable_gate_a: assert property (@(posedge mclk) disable iff (rst) !t3_enable |=> !timer3_irq)
    else $error("timer3 irq while disabled");
  t0_halt_a: assert property (@(posedge mclk) disable iff (rst) !timer0_run |=> $stable(timer0_count))
    else $error("timer0 moved while halted");
  wdt_owner_a: assert property (@(posedge mclk) disable iff (rst)
    owner_wdt && $stable(owner_wdt) |=> $stable(timer0_count))
    else $error("timer0 counted while prescaler owned by watchdog");
  rate_fast_a: assert property (@(posedge mclk) disable iff (rst)
    owner_wdt && !wdt_int_mode && mode.prescale_rate_select == 3'h0 && wdt_tick |=> wdt_timeout)
    else $error("watchdog 1:1 rate missed");
  rate_t0_a: assert property (@(posedge mclk) disable iff (rst)
    !owner_wdt && mode.prescale_rate_select == 3'h0 && t0_step |=> !t0_step)
    else $error("timer0 stepped on two ticks in a row at 1:2");
  rate_int_a: assert property (@(posedge mclk) disable iff (rst)
    owner_wdt && wdt_int_mode && mode.prescale_rate_select == RATE_MAX |-> (mask == 8'hFF))
    else $error("watchdog interrupt 1:256 mask wrong");
  t1_load_a: assert property (@(posedge mclk) disable iff (rst)
    sfr_wr && sfr_addr == ADDR_TIMER1_COUNT |=> timer1_count_load)
    else $error("timer1 load pulse missing");
  hi_write_a: assert property (@(posedge mclk) disable iff (rst)
    sfr_wr && sfr_addr == ADDR_TIMER_HIGH |=> {2'b00, timer1_upper_bits, 4'h0} == ($past(sfr_wdata) & 8'h30))
    else $error("timer1 upper bits not written");
  edge_rise_a: assert property (@(posedge mclk) disable iff (rst)
    mode.tick_source_select && !mode.tick_edge_select && src_last && !src_now |-> !tick)
    else $error("falling edge counted in rising mode");
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking testbench for the timer and prescaler control block.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tpc_pkg::*;
  // ----------------------------------------
  // Stimulus, results and the design
  // ----------------------------------------
  logic mclk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, mwr = 1'b0, mrd = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, mode_rdata, t0_cnt, pre_cnt;
  logic pin = 1'b0, osc = 1'b0, run = 1'b0, t0_ie = 1'b0, t0_clr = 1'b0, wdt_im = 1'b0, wtick = 1'b0;
  logic t3_uf = 1'b0, wdt_to, t1_ld, t0_flag, t3_flag, t3_irq, rd_seen = 1'b0, mrd_seen = 1'b0;
  logic [9:0] live1 = 10'h000, live2 = 10'h000, live3 = 10'h000;
  logic [1:0] up1, up2, up3, pw1, pw2, pw3, pw4;
  logic [7:0] q_sfr[$], q_mode[$];
  int err_count = 0, n_compared = 0, n_to = 0;

  // Free-running instruction clock, 4 ns period.
  always #2 mclk = ~mclk;

  tpc_timer_prescaler_control i_dut (.mclk(mclk), .rst(rst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .mode_write_instr(mwr),
    .mode_readback_instr(mrd), .mode_rdata(mode_rdata), .ext_count_pin(pin), .slow_osc_clk(osc),
    .timer0_run(run), .timer0_int_enable(t0_ie), .timer0_flag_clear(t0_clr), .wdt_int_mode(wdt_im),
    .wdt_tick(wtick), .wdt_timeout(wdt_to), .timer1_live(live1), .timer2_live(live2),
    .timer3_live(live3), .timer3_underflow(t3_uf), .timer1_upper_bits(up1), .timer2_upper_bits(up2),
    .timer3_upper_bits(up3), .timer1_count_load(t1_ld), .pwm1_duty_upper(pw1), .pwm2_duty_upper(pw2),
    .pwm3_duty_upper(pw3), .pwm4_duty_upper(pw4), .timer0_count(t0_cnt), .prescale_count(pre_cnt),
    .timer0_overflow_flag(t0_flag), .timer3_underflow_flag(t3_flag), .timer3_irq(t3_irq));

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic chk8(input string name, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  // Read data lands one edge after the strobe, so the oldest note is compared then.
  always @(posedge mclk) begin
    if (rd_seen) chk8("sfr_rdata", sfr_rdata, q_sfr.pop_front());
    if (mrd_seen) chk8("mode_rdata", mode_rdata, q_mode.pop_front());
    rd_seen <= sfr_rd;
    mrd_seen <= mrd;
    if (wdt_to === 1'b1) n_to <= n_to + 1;
  end

  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Strobes last one cycle; the next call waits an edge, so no signal is set twice at once.
  task automatic acc(input logic rdb, input logic [7:0] a, input logic [7:0] d);
    if (rdb) q_sfr.push_back(d);
    @(posedge mclk);
    sfr_rd <= rdb;
    sfr_wr <= !rdb;
    sfr_addr <= a;
    if (!rdb) sfr_wdata <= d;
    @(posedge mclk);
    sfr_rd <= 1'b0;
    sfr_wr <= 1'b0;
  endtask

  // The mode register has no address and is reached by its two instructions only.
  task automatic mode(input logic rdb, input logic [7:0] d);
    if (rdb) q_mode.push_back(d);
    @(posedge mclk);
    mrd <= rdb;
    mwr <= !rdb;
    sfr_wdata <= d;
    @(posedge mclk);
    mrd <= 1'b0;
    mwr <= 1'b0;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic [7:0] d, b;
    int nb;
    void'($urandom(32'hDACD));
    cyc(8);
    rst <= 1'b0;
    mode(1'b1, RST_TIMER0_MODE);
    chk8("prescale_count", pre_cnt, RST_PRESCALE);
    acc(1'b1, ADDR_SECOND_INT, RST_SECOND_INT);
    acc(1'b0, 8'h42, 8'hFF);
    acc(1'b1, 8'h42, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom);
      live1 <= 10'($urandom);
      live2 <= 10'($urandom);
      live3 <= 10'($urandom);
      acc(1'b0, ADDR_TIMER_HIGH, d);
      acc(1'b0, ADDR_TIMER3_HIGH, ~d);
      cyc(1);
      chk8("high byte fields", {up2, up1, pw2, pw1}, d);
      chk8("timer3 high fields", {2'b00, up3, pw4, pw3}, {2'b00, ~d[5:0]});
      acc(1'b1, ADDR_TIMER_HIGH, {live2[9:8], live1[9:8], d[3:0]});
      acc(1'b1, ADDR_TIMER3_HIGH, {2'b00, live3[9:8], ~d[3:0]});
    end
    acc(1'b0, ADDR_TIMER1_COUNT, 8'h5A);
    #1 chk8("timer1_count_load", {7'h00, t1_ld}, 8'h01);
    cyc(1);
    #1 chk8("timer1_count_load", {7'h00, t1_ld}, 8'h00);
    $display("test high bytes done");
    // The flag is set while disabled but only shows once the enable is on.
    acc(1'b0, ADDR_SECOND_INT, 8'h00);
    @(posedge mclk) t3_uf <= 1'b1;
    @(posedge mclk) t3_uf <= 1'b0;
    acc(1'b1, ADDR_SECOND_INT, 8'h00);
    // Writing one to the flag bit leaves it alone, so the enable goes on without a clear.
    acc(1'b0, ADDR_SECOND_INT, 8'h11);
    cyc(2);
    chk8("timer3 flag and irq", {6'h00, t3_flag, t3_irq}, 8'h03);
    acc(1'b0, ADDR_SECOND_INT, 8'h11);
    acc(1'b1, ADDR_SECOND_INT, 8'h11);
    acc(1'b0, ADDR_SECOND_INT, 8'h01);
    acc(1'b1, ADDR_SECOND_INT, 8'h01);
    $display("test timer3 interrupt done");
    // A run window of two whole divisions gives two steps whatever the prescaler phase.
    for (int r = 0; r < 8; r++) begin
      mode(1'b0, {5'h00, 3'(r)});
      mode(1'b1, {5'h00, 3'(r)});
      cyc(4);
      b = t0_cnt;
      @(posedge mclk) run <= 1'b1;
      cyc(4 << r);
      run <= 1'b0;
      cyc(6);
      chk8("timer0_count rate", t0_cnt, b + 8'h02);
    end
    b = t0_cnt;
    cyc(20);
    chk8("timer0_count halted", t0_cnt, b);
    mode(1'b0, 8'h00);
    @(posedge mclk) run <= 1'b1;
    cyc(600);
    run <= 1'b0;
    cyc(4);
    chk8("timer0 flag masked", {7'h00, t0_flag}, 8'h00);
    t0_ie <= 1'b1;
    cyc(3);
    chk8("timer0 flag", {7'h00, t0_flag}, 8'h01);
    t0_clr <= 1'b1;
    @(posedge mclk) t0_clr <= 1'b0;
    cyc(3);
    chk8("timer0 flag cleared", {7'h00, t0_flag}, 8'h00);
    $display("test timer0 rates done");
    // Two pulses at 1:2 from an aligned prescaler: the chosen edge decides when the step comes.
    for (int k = 0; k < 4; k++) begin
      mode(1'b0, {k[1], 1'b0, 1'b1, k[0], 4'h0});
      run <= 1'b1;
      cyc(8);
      b = t0_cnt;
      for (int j = 0; j < 4; j++) begin
        @(posedge mclk);
        if (k[1]) osc <= ~osc;
        else pin <= ~pin;
        cyc(6);
        if (j == 2) chk8("timer0_count edges", t0_cnt, b + (k[0] ? 8'h00 : 8'h01));
      end
      chk8("timer0_count edge pairs", t0_cnt, b + 8'h01);
    end
    run <= 1'b0;
    chk8("prescale_count", pre_cnt, RST_PRESCALE);
    $display("test timer0 edges done");
    // Two whole watchdog divisions per mode and rate yield two timeouts.
    for (int m = 0; m < 16; m++) begin
      mode(1'b0, {5'h01, 3'(m)});
      wdt_im <= m[3];
      cyc(4);
      nb = n_to;
      repeat ((m[3] ? 4 : 2) << m[2:0]) begin
        @(posedge mclk) wtick <= 1'b1;
        @(posedge mclk) wtick <= 1'b0;
      end
      cyc(4);
      chk8("watchdog timeouts", 8'(n_to - nb), 8'h02);
    end
    $display("test watchdog rates done");
    end_sim();
  end

  // A hang is cut short well beyond the expected run of about 5200 cycles.
  initial begin
    cyc(20000);
    err_count++;
    $display("unexpected run length: expected finish, seen timeout");
    end_sim();
  end
endmodule
`default_nettype wire
